// ===== src/pdc_powerdown_cal.sv
// power-down and offset calibration control with AHB-Lite registers
// assumes power-down and calibration pins are asynchronous, samples on sys_clk
// Behaviour
// RULE1 - analog and digital sections power down while their inputs are high
// RULE2 - falling digital power-down starts an offset calibration cycle
// RULE3 - calibration measures each channel's input into its own offset register
// RULE4 - after calibration each channel's offset is subtracted from every result
// RULE5 - select low takes analog inputs, high takes zero-level inputs
// RULE6 - calibration-active stays high 4096 frames, then falls
// RULE7 - both channel outputs are forced to zero during calibration
// RULE8 - about 40 output words after calibration are not yet settled
// RULE9 - controller must calibrate after power-up; offsets start undefined
// RULE10 - large reference capacitor needs analog release before digital release
// RULE11 - divider counters held in reset during power-down, start at release
// RULE12 - multiple converters share power-down signal and clocks for sync
// RULE13 - select may stay low while calibration-active steers external mux
// RULE14 - calibration-active rises as soon as digital power-down goes high
// RULE15 - calibration length counted in frame periods from the master clock
`timescale 1ns/1ps
module pdc_powerdown_cal
	import pdc_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              digital_powerdown_in,
	input  wire logic              analog_powerdown_in,
	input  wire logic              cal_source_select,
	input  wire logic [DATA_W-1:0] left_analog_in,
	input  wire logic [DATA_W-1:0] right_analog_in,
	input  wire logic [DATA_W-1:0] left_zero_level_in,
	input  wire logic [DATA_W-1:0] right_zero_level_in,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic                   cal_active_out,
	output logic                   analogPowerdown,
	output logic                   digitalPowerdown,
	output logic                   frameStb,
	output logic                   outValid,
	output logic                   outSettled,
	output pdc_pair_s              outWord,
	output logic                   irq
);
	logic dpdRunSync;
	logic apdRunSync;
	logic srcSync;
	logic dpdPrev_r;
	pdc_state_e state_r;
	pdc_state_e state_nxt;
	logic [15:0] divCnt_r;
	logic [12:0] calCnt_r;
	logic [5:0]  settleCnt_r;
	logic [IRQ_W-1:0] irqStat_r;
	logic [IRQ_W-1:0] irqMask_r;
	logic        swForceCal_r;
	logic        wrPend_r;
	logic [7:0]  wrAddr_r;
	pdc_pair_s   offset;
	pdc_pair_s   chanOut;
	logic [1:0][DATA_W-1:0] offArr;
	logic [1:0][DATA_W-1:0] outArr;

	// power-down pins enter inverted: a cleared chain then reads as powered down,
	// so no false release edge follows reset while the pin is still high

	pdc_sync u_sync_dpd
	(
		.clk   (sys_clk),
		.rst_n (rst_n),
		.din   (~digital_powerdown_in),
		.dout  (dpdRunSync)
	);

	pdc_sync u_sync_apd
	(
		.clk   (sys_clk),
		.rst_n (rst_n),
		.din   (~analog_powerdown_in),
		.dout  (apdRunSync)
	);

	pdc_sync u_sync_src
	(
		.clk   (sys_clk),
		.rst_n (rst_n),
		.din   (cal_source_select),
		.dout  (srcSync)
	);

	// a pin already low at reset still gives one release edge, so power-up calibrates
	wire logic dpdSync = ~dpdRunSync;
	wire logic apdSync = ~apdRunSync;

	// software power-down bit ORs with the pin
	wire logic pdActive = dpdSync | swForceCal_r;                       // RULE1
	wire logic pdFall   = dpdPrev_r & ~pdActive;                        // RULE2
	wire logic divWrap  = (divCnt_r == FRAME_DIV_M1);
	wire logic calLast  = (calCnt_r == CAL_LAST);
	wire logic settleLast = (settleCnt_r == SETTLE_LAST);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			PDC_OFF:    if (pdFall) state_nxt = PDC_CAL;                 // RULE2
			PDC_CAL:    if (divWrap && calLast) state_nxt = PDC_SETTLE;  // RULE6
			PDC_SETTLE: if (divWrap && settleLast) state_nxt = PDC_RUN;  // RULE8
			PDC_RUN:    state_nxt = PDC_RUN;
			default:    state_nxt = PDC_OFF;
		endcase
		if (pdActive)
			state_nxt = PDC_OFF;                                        // RULE1
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_r   <= PDC_OFF;
			dpdPrev_r <= 1'b1;
		end
		else
		begin
			state_r   <= state_nxt;
			dpdPrev_r <= pdActive;
		end
	end

	// frame divider, held at zero while powered down
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || pdActive)
			divCnt_r <= '0;                                             // RULE11
		else if (divWrap)
			divCnt_r <= '0;
		else
			divCnt_r <= divCnt_r + 16'h0001;                            // RULE15
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || state_r != PDC_CAL)
			calCnt_r <= '0;
		else if (divWrap)
			calCnt_r <= calCnt_r + 13'h0001;                            // RULE6
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || state_r != PDC_SETTLE)
			settleCnt_r <= '0;
		else if (divWrap)
			settleCnt_r <= settleCnt_r + 6'h01;                         // RULE8
	end

	wire logic calRun   = (state_r == PDC_CAL) || pdActive;
	// last frame of calibration captures the settled input
	wire logic calStore = (state_r == PDC_CAL) && divWrap && calLast;   // RULE3

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			pdc_offset_chan u_chan
			(
				.clk         (sys_clk),
				.rst_n       (rst_n),
				.sampleStb   (divWrap),
				.calRun      (calRun),                                  // RULE7
				.calStore    (calStore),
				.srcZero     (srcSync),                                 // RULE5
				.analogIn    (ch == 0 ? left_analog_in : right_analog_in),
				.zeroLevelIn (ch == 0 ? left_zero_level_in : right_zero_level_in),
				.offset_r    (offArr[ch]),
				.out_r       (outArr[ch])
			);
		end
	endgenerate

	// index 0 is the left channel, packed in the upper half
	assign offset  = {offArr[0], offArr[1]};
	assign chanOut = {outArr[0], outArr[1]};

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			cal_active_out   <= 1'b1;
			analogPowerdown  <= 1'b1;
			digitalPowerdown <= 1'b1;
			frameStb         <= 1'b0;
			outValid         <= 1'b0;
			outSettled       <= 1'b0;
		end
		else
		begin
			cal_active_out   <= pdActive || state_nxt == PDC_CAL || state_nxt == PDC_OFF; // RULE14
			analogPowerdown  <= apdSync;                                // RULE1
			digitalPowerdown <= pdActive;                               // RULE1
			frameStb         <= divWrap && !pdActive;
			outValid         <= divWrap && !pdActive;
			outSettled       <= (state_r == PDC_RUN);                   // RULE8
		end
	end

	assign outWord = chanOut;

	// interrupt events: calibration start, done, settled; set beats clear
	wire logic evtStart   = pdFall;
	wire logic evtDone    = (state_r == PDC_CAL) && (state_nxt == PDC_SETTLE);
	wire logic evtSettled = (state_r == PDC_SETTLE) && (state_nxt == PDC_RUN);
	wire logic [IRQ_W-1:0] irqEvt = {evtSettled, evtDone, evtStart};

	wire logic addrPhase = hsel && hready && (htrans == HTRANS_NSEQ);
	wire logic wrStat    = wrPend_r && (wrAddr_r == ADDR_IRQST);
	wire logic wrMask    = wrPend_r && (wrAddr_r == ADDR_IRQMSK);
	wire logic wrCtrl    = wrPend_r && (wrAddr_r == ADDR_CTRL);
	wire logic [IRQ_W-1:0] irqClr = wrStat ? hwdata[IRQ_W-1:0] : '0;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			irqStat_r    <= '0;
			irqMask_r    <= '0;
			swForceCal_r <= 1'b0;
			wrPend_r     <= 1'b0;
			wrAddr_r     <= '0;
		end
		else
		begin
			irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
			wrPend_r  <= addrPhase && hwrite;
			wrAddr_r  <= haddr[7:0];
			if (wrMask)
				irqMask_r <= hwdata[IRQ_W-1:0];
			if (wrCtrl)
				swForceCal_r <= hwdata[0];
		end
	end

	assign irq = |(irqStat_r & irqMask_r);

	wire logic [7:0] rdAddr = haddr[7:0];
	logic [31:0] rdMux;

	// unmapped offsets read zero; offsets read undefined until a calibration ran
	always_comb
	begin
		if (rdAddr == ADDR_CTRL)
			rdMux = {31'h0, swForceCal_r};
		else if (rdAddr == ADDR_STAT)
			rdMux = {25'h0, srcSync, apdSync, dpdSync, state_r, outSettled, cal_active_out};
		else if (rdAddr == ADDR_IRQST)
			rdMux = {29'h0, irqStat_r};
		else if (rdAddr == ADDR_IRQMSK)
			rdMux = {29'h0, irqMask_r};
		else if (rdAddr == ADDR_OFSL)
			rdMux = {16'h0, offset.left};
		else if (rdAddr == ADDR_OFSR)
			rdMux = {16'h0, offset.right};
		else if (rdAddr == ADDR_OUTL)
			rdMux = {16'h0, chanOut.left};
		else if (rdAddr == ADDR_OUTR)
			rdMux = {16'h0, chanOut.right};
		else
			rdMux = 32'h0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			hrdata <= '0;
		else if (addrPhase && !hwrite)
			hrdata <= rdMux;
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
endmodule // pdc_powerdown_cal

// ===== src/pdc_pkg.sv
// package for the power-down and offset calibration block
// assumes a single sys_clk domain and an AHB-Lite register port
package pdc_pkg;
	localparam int          DATA_W       = 16;
	localparam int          CAL_FRAMES   = 4096;
	localparam int          SETTLE_WORDS = 40;
	localparam int          CLK_HZ       = 50000000;
	localparam int          FRAME_DIV    = 256;
	localparam logic [15:0] FRAME_DIV_M1 = 16'h00FF;
	localparam logic [12:0] CAL_LAST     = 13'h0FFF;
	localparam logic [5:0]  SETTLE_LAST  = 6'h27;
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_STAT    = 8'h04;
	localparam logic [7:0]  ADDR_IRQST   = 8'h08;
	localparam logic [7:0]  ADDR_IRQMSK  = 8'h0C;
	localparam logic [7:0]  ADDR_OFSL    = 8'h10;
	localparam logic [7:0]  ADDR_OFSR    = 8'h14;
	localparam logic [7:0]  ADDR_OUTL    = 8'h18;
	localparam logic [7:0]  ADDR_OUTR    = 8'h1C;
	localparam int          IRQ_W        = 3;
	localparam int          IRQ_CALSTART = 0;
	localparam int          IRQ_CALDONE  = 1;
	localparam int          IRQ_SETTLED  = 2;
	localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

	typedef enum logic [1:0]
	{
		PDC_OFF    = 2'b00,
		PDC_CAL    = 2'b01,
		PDC_SETTLE = 2'b10,
		PDC_RUN    = 2'b11
	} pdc_state_e;

	typedef struct packed
	{
		logic [DATA_W-1:0] left;
		logic [DATA_W-1:0] right;
	} pdc_pair_s;
endpackage

// ===== src/pdc_sync.sv
// three-flop synchroniser for one level input
// assumes input is asynchronous to clk; change accepted when stages 2 and 3 agree
`timescale 1ns/1ps
module pdc_sync
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      dout
);
	logic [2:0] stage_r;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stage_r <= 3'h0;
			dout    <= 1'b0;
		end
		else
		begin
			stage_r <= {stage_r[1:0], din};
			if (stage_r[1] == stage_r[2])
				dout <= stage_r[2];
		end
	end
endmodule // pdc_sync

// ===== src/pdc_offset_chan.sv
// one channel: offset store, subtraction and calibration zeroing
// assumes sampleStb marks a new conversion word, one cycle wide
`timescale 1ns/1ps
module pdc_offset_chan
	import pdc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              sampleStb,
	input  wire logic              calRun,
	input  wire logic              calStore,
	input  wire logic              srcZero,
	input  wire logic [DATA_W-1:0] analogIn,
	input  wire logic [DATA_W-1:0] zeroLevelIn,
	output logic      [DATA_W-1:0] offset_r,
	output logic      [DATA_W-1:0] out_r
);
	wire logic [DATA_W-1:0] calIn = srcZero ? zeroLevelIn : analogIn; // RULE5
	wire logic [DATA_W-1:0] corrected = DATA_W'(analogIn - offset_r); // RULE4

	// offset not cleared by reset: it is only valid after a calibration
	always_ff @(posedge clk)
	begin
		if (calStore)
			offset_r <= calIn; // RULE3
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			out_r <= '0;
		else if (calRun)
			out_r <= '0; // RULE7
		else if (sampleStb)
			out_r <= corrected;
	end
endmodule // pdc_offset_chan

// ===== tb/pdc_powerdown_cal_assertions.sv
// port checker for pdc_powerdown_cal
// assumes one sys_clk domain, synchronous active-low reset
`timescale 1ns/1ps
module pdc_chk
	import pdc_pkg::*;
(
	input wire logic      sys_clk,
	input wire logic      rst_n,
	input wire logic      analog_powerdown_in,
	input wire logic      cal_active_out,
	input wire logic      analogPowerdown,
	input wire logic      digitalPowerdown,
	input wire logic      frameStb,
	input wire logic      outValid,
	input wire logic      outSettled,
	input wire pdc_pair_s outWord
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_APD: assert property ($rose(analog_powerdown_in) |-> ##[2:6] analogPowerdown)
		else $error("analog power-down late");
	AST_CAL_ACTIVE_OUT_RISE: assert property ($rose(digitalPowerdown) |-> ##[0:2] cal_active_out)
		else $error("cal active late");
	AST_CAL_HOLD: assert property ($fell(digitalPowerdown) |-> cal_active_out[*8])
		else $error("cal active dropped");
	// one cycle of grace: both outputs are registered from the state
	AST_ZERO: assert property (cal_active_out[*2] |-> outWord == '0)
		else $error("output not zero");
	AST_PD_FRAME: assert property (digitalPowerdown[*3] |-> !frameStb)
		else $error("frame in power-down");
	AST_GAP: assert property (frameStb |-> ##256 (frameStb || digitalPowerdown))
		else $error("frame spacing");
	AST_VALID: assert property (outValid == frameStb)
		else $error("valid off frame");
	AST_SETTLE: assert property ($rose(outSettled) |-> !cal_active_out)
		else $error("settled in cal");
	COV_CAL: cover property ($fell(digitalPowerdown));
	COV_ABORT: cover property (cal_active_out && $rose(digitalPowerdown));
	COV_FRAME: cover property (frameStb && cal_active_out);
endmodule // pdc_chk

bind pdc_powerdown_cal pdc_chk u_chk (.sys_clk, .rst_n, .analog_powerdown_in, .cal_active_out,
	.analogPowerdown, .digitalPowerdown, .frameStb, .outValid, .outSettled, .outWord);

// ===== tb/pdc_ctrl_model.sv
// system controller model driving power-down, source select and inputs
// assumes pdReq from the bench and cal_active_out from the device
`timescale 1ns/1ps
module pdc_ctrl_model
	import pdc_pkg::*;
(
	input  wire logic pdReq,
	input  wire logic selReq,
	input  wire logic cal_active_out,
	output logic      digital_powerdown_in,
	output logic      analog_powerdown_in,
	output logic      cal_source_select,
	output pdc_pair_s ana
);
	// one line for both pins; cal cycle follows every power-up
	assign digital_powerdown_in = pdReq;
	// small reference cap, so analog needs no early release
	assign analog_powerdown_in = pdReq;
	// select low by default, front end fed small offsets 0x0005 and 0xFFFB by the mux during cal
	assign cal_source_select = selReq;
	assign ana = cal_active_out ? 32'h0005FFFB : 32'h1234EDCC;
endmodule // pdc_ctrl_model

// ===== tb/pdc_powerdown_cal_bench.sv
// self-checking bench for pdc_powerdown_cal
// assumes the model drives the pins and the bench is the AHB-Lite master
`timescale 1ns/1ps
module pdc_powerdown_cal_bench
	import pdc_pkg::*;
;
	logic        sys_clk, rst_n, pdReq, hsel, hwrite, hreadyout, hresp, irq, frameStb;
	logic        cal_active_out, analogPowerdown, digitalPowerdown, outValid, selIn;
	logic        digital_powerdown_in, analog_powerdown_in, outSettled, selReq;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	pdc_pair_s   ana, outWord;
	int          error_cnt, num_checks;

	always #10 sys_clk = ~sys_clk;

	pdc_ctrl_model model (.pdReq, .selReq, .cal_active_out, .digital_powerdown_in,
		.analog_powerdown_in, .cal_source_select(selIn), .ana);

	pdc_powerdown_cal uut (.sys_clk, .rst_n, .digital_powerdown_in, .analog_powerdown_in,
		.cal_source_select(selIn), .left_analog_in(ana.left), .right_analog_in(ana.right),
		.left_zero_level_in(16'h0000), .right_zero_level_in(16'h0000), .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .cal_active_out, .analogPowerdown, .digitalPowerdown, .frameStb, .outValid,
		.outSettled, .outWord, .irq);

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// bounded wait so a dead design cannot hang the run
	task automatic await(input bit onFrame, input int lim);
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while ((onFrame ? frameStb : hreadyout) !== 1'h1 && n < lim);
		if ((onFrame ? frameStb : hreadyout) !== 1'h1)
		begin
			error_cnt++;
			wrap_up();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'h1;
		htrans <= HTRANS_NSEQ;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		await(1'h0, 20);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= wd;
		await(1'h0, 20);
		rd = hrdata;
		check(hresp, 1'h0);
	endtask

	task automatic s_reset();
		check({cal_active_out, analogPowerdown, digitalPowerdown}, 3'h7);
		bus(1'h0, ADDR_STAT, 32'h0);
		check(rd & 32'h31, 32'h31);
		check(outWord, 32'h0);
	endtask

	task automatic s_cal();
		bus(1'h1, ADDR_IRQMSK, 32'h7);
		pdReq <= 1'h0;
		await(1'h1, 600);
		check(outValid, 1'h1);
		check(outWord, 32'h0);
		check(outSettled, 1'h0);
		check({cal_active_out, digitalPowerdown, irq}, 3'h5);
		repeat (256) @(posedge sys_clk);
		check(frameStb, 1'h1);
		bus(1'h0, ADDR_IRQST, 32'h0);
		check(rd[IRQ_CALSTART], 1'h1);
		bus(1'h1, ADDR_IRQMSK, 32'h0);
		@(posedge sys_clk);
		check(irq, 1'h0);
		bus(1'h1, ADDR_IRQMSK, 32'h7);
		bus(1'h1, ADDR_IRQST, 32'h1);
		bus(1'h0, ADDR_IRQST, 32'h0);
		check(rd, 32'h0);
		check(irq, 1'h0);
		bus(1'h0, 8'h40, 32'h0);
		check(rd, 32'h0);
	endtask

	// power-down again in mid-calibration
	task automatic s_abort();
		int n;
		pdReq <= 1'h1;
		repeat (8) @(posedge sys_clk);
		check({cal_active_out, analogPowerdown, digitalPowerdown}, 3'h7);
		n = 0;
		repeat (300)
		begin
			@(posedge sys_clk);
			if (frameStb !== 1'h0)
				n++;
		end
		check(n, 32'h0);
		selReq <= 1'h1;
		repeat (6) @(posedge sys_clk);
		bus(1'h0, ADDR_STAT, 32'h0);
		check(rd[6], 1'h1);
	endtask

	initial
	begin
		sys_clk = 1'h0;
		rst_n = 1'h0;
		pdReq = 1'h1;
		selReq = 1'h0;
		hsel = 1'h0;
		hwrite = 1'h0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		error_cnt = 0;
		num_checks = 0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		s_reset();
		s_cal();
		s_abort();
		wrap_up();
	end
endmodule // pdc_powerdown_cal_bench
